/* File: logic/snc_pkg.sv */
// Overview of operation
// [RULE1] Only data input is the modulator's one-bit stream; ones density carries value.
// [RULE2] Four cascaded moving sums over N samples, normalised by N, decimated by N.
// [RULE3] Output words arrive at 5 Hz; sample rate is N times that rate.
// [RULE4] Results count as settled only after four full 200 ms output periods.
// [RULE5] All decimation timing derives from a 4.9152 MHz master clock rate.
// [RULE6] Datapath holds values 25% beyond full scale without wrapping or clipping.
// [RULE7] Output is a signed count; 1 mV per count wide range, 3.5 digits.
// [RULE8] Results beyond displayable limits raise separate overrange and underrange flags.
// [RULE9] Internal offset is measured and subtracted continuously with no external trigger; the code measures it in a zero phase every OFS_EVERY words.
// [RULE10] Decimation ratio is 128 for 3.5 digits and 1024 for 4.5 digits.
// [RULE11] Power-up reset clears all accumulators and decimation state.
// [RULE12] A one-cycle valid strobe accompanies each new output word.
`default_nettype none
package snc_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int MCLK_HZ = 4_915_200;
    localparam int OUT_HZ = 5;
    localparam int OUT_PERIOD_MS = 200;
    localparam int SETTLE_PERIODS = 4;
    localparam int SETTLE_MS = SETTLE_PERIODS * OUT_PERIOD_MS;
    localparam int ORDER = 4;
    localparam int OSR_LOG2_35 = 7;
    localparam int OSR_LOG2_45 = 10;
    localparam int FS_COUNT_35 = 2000;
    localparam int FS_COUNT_45 = 20000;
    localparam int COUNT_UV_35 = 1000;
    localparam int COUNT_UV_45 = 100;
    localparam int HEAD_NUM = 5;
    localparam int HEAD_DEN = 4;
    localparam int OFS_EVERY = 50;
    localparam logic [31:0] PH_INC = 32'(MCLK_HZ);
    localparam logic [31:0] PH_MOD = 32'(CLK_HZ);
    typedef enum logic [0:0] {
        SNC_CONV = 1'b0,
        SNC_ZERO = 1'b1
    } snc_mode_t;
endpackage
`default_nettype wire

/* File: logic/snc_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface snc_if #(parameter int W = 30);
    logic smp_en;
    logic smp_bit;
    logic word_vld;
    logic [W-1:0] word;
    modport filt (input smp_en, input smp_bit, output word_vld, output word);
    modport ctl (output smp_en, output smp_bit, input word_vld, input word);
endinterface
`default_nettype wire

/* File: logic/snc_cic.sv */
`timescale 1ns/100ps
`default_nettype none
module snc_cic #(
    parameter int OSR_LOG2 = snc_pkg::OSR_LOG2_35
) (
    input wire logic core_clk,
    input wire logic rst_n,
    snc_if.filt f
);
    import snc_pkg::*;
    localparam int W = ORDER * OSR_LOG2 + 2;
    localparam logic [W-1:0] ONE = W'(1);
    localparam logic [W-1:0] MINUS_ONE = '1;

    typedef struct packed {
        logic [ORDER-1:0][W-1:0] integ;
        logic [ORDER-1:0][W-1:0] dly;
        logic [OSR_LOG2-1:0] phase;
        logic [W-1:0] word;
        logic vld;
    } snc_cic_st_t;

    snc_cic_st_t cur_r, cur_nxt;
    logic [W-1:0] acc, tmp;

    ////////////////////////////////////////////////////////////////////////
    // Integrators run modulo 2^W; the combs undo any wrap exactly, so the
    // decimated word is exact as long as it fits W bits, which it does.
    always_comb begin
        acc = '0;
        tmp = '0;
        cur_nxt = cur_r;
        cur_nxt.vld = 1'b0;
        if (f.smp_en) begin
            // [RULE1] bit to +/-1
            cur_nxt.integ[0] = cur_r.integ[0] + (f.smp_bit ? ONE : MINUS_ONE);
            // [RULE2] integrator cascade
            for (int k = 1; k < ORDER; k++) begin
                cur_nxt.integ[k] = cur_r.integ[k] + cur_r.integ[k-1];
            end
            cur_nxt.phase = cur_r.phase + 1'b1;
            // [RULE10] decimate by N
            if (cur_r.phase == '1) begin
                acc = cur_r.integ[ORDER-1];
                for (int k = 0; k < ORDER; k++) begin
                    tmp = acc - cur_r.dly[k];
                    cur_nxt.dly[k] = acc;
                    acc = tmp;
                end
                cur_nxt.word = acc;
                cur_nxt.vld = 1'b1;
            end
        end
    end

    // [RULE11] cleared at reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign f.word_vld = cur_r.vld;
    assign f.word = cur_r.word;

    ////////////////////////////////////////////////////////////////////////
    word_after_sample_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        f.word_vld |-> $past(f.smp_en)) // [RULE2]
        else $error("Filter word without a sample.");
    word_on_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        f.word_vld |-> cur_r.phase == '0) // [RULE10]
        else $error("Filter word off the decimation boundary.");
endmodule
`default_nettype wire

/* File: logic/snc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module snc_top #(
    parameter int OSR_LOG2 = snc_pkg::OSR_LOG2_35,
    parameter int FS_COUNT = snc_pkg::FS_COUNT_35,
    parameter int OUT_W = 16,
    parameter int SMP_DIV = snc_pkg::MCLK_HZ / (snc_pkg::OUT_HZ << OSR_LOG2),
    parameter int OFS_EVERY = snc_pkg::OFS_EVERY
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic mod_bit,
    output logic signed [OUT_W-1:0] result,
    output logic result_vld,
    output logic over_range,
    output logic under_range,
    output logic settled,
    output logic zero_sel
);
    import snc_pkg::*;
    localparam int RAW_W = ORDER * OSR_LOG2 + 2;
    localparam int HEAD_W = 20;
    localparam int SHIFT = ORDER * OSR_LOG2;
    localparam logic signed [HEAD_W-1:0] HEAD_CNT = HEAD_W'(FS_COUNT * HEAD_NUM / HEAD_DEN);
    localparam logic signed [OUT_W-1:0] LIM = OUT_W'(FS_COUNT - 1);
    localparam logic [15:0] DIV_LAST = 16'(SMP_DIV - 1);
    localparam logic [7:0] WORD_LAST = 8'(OFS_EVERY - 1);
    localparam logic [2:0] SETTLE_N = 3'(SETTLE_PERIODS);

    typedef struct packed {
        logic [31:0] ph;
        logic [15:0] div;
        logic smp_en;
        logic smp_bit;
        snc_mode_t mode;
        logic [7:0] wcnt;
        logic [2:0] settle;
        logic signed [OUT_W-1:0] ofs;
        logic signed [OUT_W-1:0] result;
        logic vld;
        logic over;
        logic under;
        logic settled;
        logic zero_sel;
    } snc_top_st_t;

    snc_top_st_t cur_r, cur_nxt;
    snc_if #(.W(RAW_W)) f_if ();

    snc_cic #(.OSR_LOG2(OSR_LOG2)) snc_cic_inst (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .f(f_if.filt)
    );

    // Full-scale density (+/-0.8) maps to +/-FS_COUNT; density +/-1 leaves 25% headroom.
    // A limitation: reading minus offset must fit OUT_W bits, so the wide variant with a
    // large offset wants a wider output.
    // [RULE6] headroom scaling
    function automatic logic signed [OUT_W-1:0] scale_raw(input logic signed [RAW_W-1:0] raw);
        logic signed [RAW_W+HEAD_W-1:0] prod;
        prod = (RAW_W + HEAD_W)'(raw) * (RAW_W + HEAD_W)'(HEAD_CNT);
        scale_raw = OUT_W'(prod >>> SHIFT);
    endfunction

    // [RULE8] display limits
    function automatic logic above_range(input logic signed [OUT_W-1:0] val);
        above_range = val > LIM;
    endfunction

    function automatic logic below_range(input logic signed [OUT_W-1:0] val);
        below_range = val < -LIM;
    endfunction

    logic signed [OUT_W-1:0] scaled, count;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.smp_en = 1'b0;
        cur_nxt.vld = 1'b0;
        // [RULE2] normalise by N^4
        scaled = scale_raw($signed(f_if.word));
        // [RULE9] offset subtraction
        count = scaled - cur_r.ofs;
        // The accumulator averages exactly the master rate; single ticks jitter by one
        // core cycle, which moves sample instants only and leaves the word rate exact.
        // [RULE5] master-rate phase step
        if (cur_r.ph >= PH_MOD - PH_INC) begin
            cur_nxt.ph = cur_r.ph + PH_INC - PH_MOD;
            // [RULE3] sample rate N*5Hz
            if (cur_r.div == DIV_LAST) begin
                cur_nxt.div = '0;
                cur_nxt.smp_en = 1'b1;
                cur_nxt.smp_bit = mod_bit;
            end else begin
                cur_nxt.div = cur_r.div + 1'b1;
            end
        end else begin
            cur_nxt.ph = cur_r.ph + PH_INC;
        end
        if (f_if.word_vld) begin
            cur_nxt.wcnt = cur_r.wcnt + 1'b1;
            case (cur_r.mode)
                SNC_CONV: begin
                    // [RULE12] word strobe
                    cur_nxt.vld = 1'b1;
                    // [RULE7] signed count out
                    cur_nxt.result = count;
                    // [RULE8] range flags
                    cur_nxt.over = above_range(count);
                    cur_nxt.under = below_range(count);
                    // The count saturates so that a long run of words never wraps it.
                    // [RULE4] settle count
                    if (cur_r.settle != SETTLE_N) begin
                        cur_nxt.settle = cur_r.settle + 1'b1;
                    end
                    cur_nxt.settled = cur_r.settle == SETTLE_N;
                    // [RULE9] periodic zero phase
                    if (cur_r.wcnt == WORD_LAST) begin
                        cur_nxt.mode = SNC_ZERO;
                        cur_nxt.zero_sel = 1'b1;
                        cur_nxt.wcnt = '0;
                    end
                end
                SNC_ZERO: begin
                    // The filter needs four full words of shorted input first.
                    // These words are never strobed, so the display keeps its last reading.
                    if (cur_r.wcnt == 8'(SETTLE_PERIODS)) begin
                        cur_nxt.ofs = scaled;
                        cur_nxt.mode = SNC_CONV;
                        cur_nxt.zero_sel = 1'b0;
                        cur_nxt.wcnt = '0;
                        cur_nxt.settle = '0;
                        cur_nxt.settled = 1'b0;
                    end
                end
                default: begin
                    cur_nxt.mode = SNC_CONV;
                end
            endcase
        end
    end

    // [RULE11] power-up state, starts with an offset measurement
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_r <= '{mode: SNC_ZERO, zero_sel: 1'b1, default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign f_if.smp_en = cur_r.smp_en;
    assign f_if.smp_bit = cur_r.smp_bit;
    assign result = cur_r.result;
    assign result_vld = cur_r.vld;
    assign over_range = cur_r.over;
    assign under_range = cur_r.under;
    assign settled = cur_r.settled;
    assign zero_sel = cur_r.zero_sel;

    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    strobe_one_cycle_a: assert property (result_vld |=> !result_vld) // [RULE12]
        else $error("Result strobe longer than one cycle.");
    strobe_follows_word_a: assert property (
        f_if.word_vld && cur_r.mode == SNC_CONV |=> result_vld) // [RULE12]
        else $error("Converted word without result strobe.");
    sample_spacing_a: assert property (f_if.smp_en |=> !f_if.smp_en [*8]) // [RULE5]
        else $error("Sample enables too close together.");
    sample_bit_a: assert property (f_if.smp_en |-> f_if.smp_bit == $past(mod_bit)) // [RULE1]
        else $error("Sample bit is not the modulator bit.");
    over_flag_a: assert property (result_vld |-> over_range == above_range(result)) // [RULE8]
        else $error("Overrange flag disagrees with result.");
    under_flag_a: assert property (result_vld |-> under_range == below_range(result)) // [RULE8]
        else $error("Underrange flag disagrees with result.");
    settle_restart_a: assert property ($fell(zero_sel) |-> !settled) // [RULE4]
        else $error("Settled shown right after offset phase.");
    zero_quiet_a: assert property (zero_sel && $past(zero_sel) |-> !result_vld) // [RULE9]
        else $error("Result strobe during offset phase.");
    offset_update_a: assert property ($changed(cur_r.ofs) |-> $fell(zero_sel)) // [RULE9]
        else $error("Offset changed outside end of offset phase.");
    result_hold_a: assert property (!result_vld |-> $stable(result)) // [RULE7]
        else $error("Result changed without a strobe.");
    flags_hold_a: assert property (
        !result_vld |-> $stable(over_range) && $stable(under_range)) // [RULE8]
        else $error("Range flag changed without a strobe.");
    range_excl_a: assert property (!(over_range && under_range)) // [RULE8]
        else $error("Overrange and underrange shown together.");
    zero_step_a: assert property ($changed(zero_sel) |-> $past(f_if.word_vld)) // [RULE9]
        else $error("Offset phase switched off a word boundary.");
    bit_hold_a: assert property (!f_if.smp_en |-> $stable(f_if.smp_bit)) // [RULE1]
        else $error("Sample bit changed between samples.");
    settled_count_a: assert property (settled |-> cur_r.settle == SETTLE_N) // [RULE4]
        else $error("Settled shown before four full periods.");
    settle_step_a: assert property (result_vld |-> cur_r.settle != '0) // [RULE4]
        else $error("Strobe did not advance the settle count.");
    strobe_from_word_a: assert property (result_vld |-> $past(f_if.word_vld)) // [RULE12]
        else $error("Result strobe without a filter word.");
    word_spacing_a: assert property (f_if.word_vld |=> !f_if.word_vld [*8]) // [RULE3]
        else $error("Filter words too close together.");
    sample_on_div_a: assert property (f_if.smp_en |-> $past(cur_r.div) == DIV_LAST) // [RULE3]
        else $error("Sample taken off the divider end.");

    settled_cover_c: cover property (result_vld && settled);
    over_cover_c: cover property (result_vld && over_range);
    under_cover_c: cover property (result_vld && under_range);
    offset_cover_c: cover property ($fell(zero_sel));
    zero_start_c: cover property ($rose(zero_sel));
endmodule
`default_nettype wire

/* File: testbench/snc_mod_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Single-bit modulator with its input-shorting switch.
// The shorted input reads as ofs_lvl, so a badly offset front end is easy to mimic.
module snc_mod_model (
    input wire logic core_clk,
    input wire logic zero_sel,
    input wire logic ofs_lvl,
    input wire logic in_lvl,
    output logic mod_bit
);
    always_ff @(posedge core_clk) begin
        mod_bit <= zero_sel ? ofs_lvl : in_lvl;
    end
endmodule
`default_nettype wire

/* File: testbench/sinc4_decimation_filter_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sinc4_decimation_filter_bench;
    import snc_pkg::*;
    // A short ratio and sample divider keep the run small; expectations scale with them.
    localparam int L2 = 5;
    localparam int DIV = 9;
    localparam int OE = 6;
    localparam int FS = FS_COUNT_35;
    localparam int FSH = FS * HEAD_NUM / HEAD_DEN;
    localparam real PER = real'((1 << L2) * DIV) * CLK_HZ / MCLK_HZ;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ofs_lvl = 1'b0;
    logic in_lvl = 1'b0;
    logic mod_bit;
    logic signed [15:0] result;
    logic result_vld, over_range, under_range, settled, zero_sel;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] lfsr = 32'h3E265F72;

    snc_top #(.OSR_LOG2(L2), .FS_COUNT(FS), .OUT_W(16), .SMP_DIV(DIV), .OFS_EVERY(OE))
        snc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .mod_bit(mod_bit),
        .result(result), .result_vld(result_vld), .over_range(over_range),
        .under_range(under_range), .settled(settled), .zero_sel(zero_sel));
    snc_mod_model snc_mod_model_inst (.core_clk(core_clk), .zero_sel(zero_sel),
        .ofs_lvl(ofs_lvl), .in_lvl(in_lvl), .mod_bit(mod_bit));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic signed [15:0] exp_count(input logic ofs, input logic inl);
        return 16'((inl ? FSH : -FSH) - (ofs ? FSH : -FSH));
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic signed [15:0] got, input logic signed [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t result %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_gap(input int gap, input real want);
        n_tests++;
        if (real'(gap) < want - 2.0 || real'(gap) > want + 2.0) begin
            bad_count++;
            $display("[ERR] %0t word spacing %0d expected %0.1f", $time, gap, want);
        end
    endtask

    // The cycle after each strobe is spent by the caller, hence the count starts at one.
    task automatic wait_word(output int gap);
        gap = 1;
        do begin
            @(posedge core_clk);
            #1;
            gap++;
            if (gap > 8 * int'(PER)) begin
                bad_count++;
                $display("[ERR] %0t no result strobe", $time);
                final_report();
            end
        end while (result_vld !== 1'b1);
    endtask

    task automatic run_block(input logic ofs, input logic inl, input bit first);
        int gap;
        logic signed [15:0] e;
        e = exp_count(ofs, inl);
        ofs_lvl = ofs;
        in_lvl = inl;
        for (int k = 1; k <= OE; k++) begin
            wait_word(gap);
            if (k == 1 && !first) chk_gap(gap, 6.0 * PER);
            if (k > 1) chk_gap(gap, PER);
            if (k < OE) chk_bit(zero_sel, 1'b0, "zero_sel");
            if (k == OE) chk_bit(zero_sel, 1'b1, "zero_sel");
            chk_bit(settled, k >= 5, "settled");
            if (k >= 5) begin
                chk_val(result, e);
                chk_bit(over_range, e > FS - 1, "over_range");
                chk_bit(under_range, e < -(FS - 1), "under_range");
            end
            @(posedge core_clk);
            #1;
            chk_bit(result_vld, 1'b0, "result_vld");
        end
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        chk_val(result, 16'sh0000);
        chk_bit(zero_sel, 1'b1, "zero_sel");
        chk_bit(settled, 1'b0, "settled");
        rst_n = 1'b1;
        run_block(1'b1, 1'b0, 1'b1);
        run_block(1'b0, 1'b1, 1'b0);
        repeat (2) begin
            lfsr = lfsr_next(lfsr);
            run_block(lfsr[3], lfsr[17], 1'b0);
        end
        rst_n = 1'b0;
        #2;
        chk_val(result, 16'sh0000);
        chk_bit(zero_sel, 1'b1, "zero_sel");
        chk_bit(over_range, 1'b0, "over_range");
        final_report();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        bad_count++;
        $display("[ERR] %0t run did not finish", $time);
        final_report();
    end
endmodule
`default_nettype wire
